// *** core/fdcs_params.svh ***
// offsets, field positions, opcodes and timing counts of the floppy command block
`ifndef FDCS_PARAMS_SVH
`define FDCS_PARAMS_SVH
// register byte addresses
`define FDCS_A_MAIN 8'h00
`define FDCS_A_DATA 8'h04
`define FDCS_A_ST1 8'h08
`define FDCS_A_ST2 8'h0c
`define FDCS_A_ST3 8'h10
`define FDCS_A_CFG 8'h14
`define FDCS_A_SPEC 8'h18
// main status fields
`define FDCS_MAIN_HOST_REQ 7
`define FDCS_MAIN_TO_HOST 6
`define FDCS_MAIN_EXEC 5
`define FDCS_MAIN_BUSY 4
// command opcodes (low five bits)
`define FDCS_OP_SPECIFY 5'h03
`define FDCS_OP_SENSE_DRV 5'h04
`define FDCS_OP_SENSE_INT 5'h08
// status zero values
`define FDCS_ST0_INVALID 8'h80
`define FDCS_ST0_READY_CHG 8'hc0
`define FDCS_ST0_SEEK_OK 8'h20
`define FDCS_ST0_SEEK_BAD 8'h60
// status register one / two bit positions
`define FDCS_ST1_WRITE_BLOCKED 1
`define FDCS_ST1_ID_ABSENT 0
`define FDCS_ST2_DELETED 6
`define FDCS_ST2_DATA_CRC 5
`define FDCS_ST2_WRONG_CYL 4
`define FDCS_ST2_SCAN_HIT 3
`define FDCS_ST2_SCAN_NOMATCH 2
`define FDCS_ST2_BAD_TRACK 1
`define FDCS_ST2_DATA_ABSENT 0
// timer scaling: the coded values are in ms at the nominal 10 MHz clock
`define FDCS_MS_NS 1000000
`define FDCS_CLK_NS 100
`define FDCS_MS_CYCLES (`FDCS_MS_NS / `FDCS_CLK_NS)
`define FDCS_UNLOAD_STEP_MS 16
`define FDCS_LOAD_STEP_MS 2
`define FDCS_STEP_MAX_MS 16
`define FDCS_BAD_CYL 8'hff
`endif

// *** core/fdcs_pkg.sv ***
// types of the floppy command and status block
`default_nettype none
package fdcs_pkg;
  typedef enum logic [1:0] {
    FDCS_IDLE,
    FDCS_PARAM,
    FDCS_EXEC,
    FDCS_RESULT
  } fdcs_phase_e;
endpackage
`default_nettype wire

// *** core/fdcs_core.sv ***
// command interpreter, status registers and specify timers of the controller
`timescale 1ns/1ps
`default_nettype none
`include "fdcs_params.svh"

// Overview of operation
// R1: interrupt on result entry, drive ready change, and seek/recalibrate end (ready changes are ignored while seek_pend is set).
// R2: non-DMA mode also interrupts during execution for each data byte.
// R3: sense-interrupt clears the interrupt and reports cause in bits 7..5.
// R4: host must follow each seek/recalibrate with a sense-interrupt.
// R5: cause codes: ready change C0, seek normal 20, seek abnormal 60.
// R6: unload delay 16..240 ms in 16 ms steps after read/write end.
// R7: step spacing 1..16 ms, inverted code, F gives 1 ms.
// R8: load delay 2..254 ms in 2 ms steps after head load rises.
// R9: timers follow controller clock; all intervals double at half clock.
// R10: host should program step spacing 1 ms above drive minimum.
// R11: dma_bypass set selects non-DMA, cleared selects DMA.
// R12: sense-drive-status returns status register three with live drive lines.
// R13: undefined command: no interrupt, result phase, status zero 80H.
// R14: unanswered seek interrupt makes the next other command invalid.
// R15: write_blocked set on write protect during write or format.
// R16: id_field_absent on missing ID or data mark, with data_mark_absent.
// R17: status register two bit 7 always reads zero.
// R18: deleted_mark_seen on deleted mark during read data or scan.
// R19: data_crc_error on CRC error in the data field.
// R20: wrong_cyl_flag on cylinder mismatch; bad_track_flag when medium is FF.
// R21: scan_hit on equal condition; scan_no_match when no sector matches.
// R22: data_mark_absent when neither data nor deleted mark is found.
// R23: status three: fault, protect, ready, track0, two-sided, side, units.
// R24: sense-interrupt result is status zero then present cylinder.
module fdcs_core #(
  parameter int MS_CYCLES = `FDCS_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive lines
  input wire logic drv_fault,
  input wire logic drv_write_protect,
  input wire logic drv_ready,
  input wire logic drv_track_zero,
  input wire logic drv_two_sided,
  output logic side_select_state,
  output logic [1:0] unit_sel_state,
  // execution engine events
  input wire logic exec_done,
  input wire logic exec_byte_req,
  input wire logic exec_writing,
  input wire logic exec_reading,
  input wire logic exec_scanning,
  input wire logic seek_end,
  input wire logic seek_abnormal,
  input wire logic [7:0] present_cylinder,
  input wire logic ev_id_missing,
  input wire logic ev_data_mark_missing,
  input wire logic ev_deleted_mark,
  input wire logic ev_data_crc,
  input wire logic cyl_check,
  input wire logic [7:0] medium_cyl,
  input wire logic [7:0] id_cylinder_store,
  input wire logic ev_scan_equal,
  input wire logic ev_scan_none,
  output logic exec_start,
  output logic [7:0] exec_opcode,
  output logic param_strobe,
  output logic [7:0] param_byte,
  output logic int_out,
  // timer starts and expiries
  input wire logic rw_exec_end,
  input wire logic step_gap_start,
  input wire logic head_load_rise,
  output logic head_unload,
  output logic step_gap_done,
  output logic rw_start_ok,
  output logic dma_bypass
);

  // ==========================================================
  // state
  typedef struct packed {
    fdcs_pkg::fdcs_phase_e phase;
    logic [7:0] opcode;
    logic [1:0] pleft;
    logic [3:0] unload_delay;
    logic [3:0] step_interval;
    logic [6:0] load_delay;
    logic dma_bypass;
    logic half_clk;
    logic int_pend;
    logic seek_pend;
    logic [7:0] cause;
    logic int_out;
    logic [7:0] res0;
    logic [7:0] res1;
    logic [1:0] res_cnt;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st3;
    logic hd;
    logic [1:0] us;
    logic ready_q;
    logic [13:0] pre;
    logic ms_odd;
    logic ms_tick;
    logic [7:0] unl_cnt;
    logic unl_run;
    logic [4:0] stp_cnt;
    logic stp_run;
    logic [7:0] ld_cnt;
    logic ld_run;
    logic unl_done;
    logic stp_done;
    logic ld_done;
    logic exec_start;
    logic [7:0] exec_op;
    logic param_stb;
    logic [7:0] param_byte;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fdcs_state_s;

  fdcs_state_s st_reg;
  fdcs_state_s st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // ==========================================================
  // reset release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // helpers
  function automatic logic is_ext(input logic [4:0] op);
    case (op)
      5'h02, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0c, 5'h0d,
      5'h0f, 5'h11, 5'h19, 5'h1d: is_ext = 1'b1;
      default: is_ext = 1'b0;
    endcase
  endfunction

  logic acc;
  logic wr_data;
  logic rd_data;
  logic cmd_take;
  logic [4:0] op_in;
  logic ready_chg;
  logic ev_any;
  logic bad_cmd;
  logic [31:0] rd_mux;
  logic mapped;

  always_comb begin
    acc = psel && penable && st_reg.pready;
    wr_data = acc && pwrite && (paddr == `FDCS_A_DATA);
    rd_data = acc && !pwrite && (paddr == `FDCS_A_DATA);
    cmd_take = wr_data && (st_reg.phase == fdcs_pkg::FDCS_IDLE);
    op_in = pwdata[4:0];
    ready_chg = drv_ready != st_reg.ready_q;
    ev_any = ready_chg || seek_end || exec_done;
    bad_cmd = !(op_in == `FDCS_OP_SPECIFY || op_in == `FDCS_OP_SENSE_DRV ||
      op_in == `FDCS_OP_SENSE_INT || is_ext(op_in)) ||
      (st_reg.seek_pend && op_in != `FDCS_OP_SENSE_INT); // [R14]
    mapped = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `FDCS_A_MAIN: begin
        rd_mux[`FDCS_MAIN_HOST_REQ] = st_reg.phase != fdcs_pkg::FDCS_EXEC ||
          (st_reg.dma_bypass && exec_byte_req);
        rd_mux[`FDCS_MAIN_TO_HOST] = st_reg.phase == fdcs_pkg::FDCS_RESULT;
        rd_mux[`FDCS_MAIN_EXEC] = st_reg.phase == fdcs_pkg::FDCS_EXEC &&
          st_reg.dma_bypass;
        rd_mux[`FDCS_MAIN_BUSY] = st_reg.phase != fdcs_pkg::FDCS_IDLE;
      end
      `FDCS_A_DATA: rd_mux[7:0] = st_reg.res_cnt != 2'h0 ? st_reg.res0 :
        8'h0;
      `FDCS_A_ST1: rd_mux[7:0] = st_reg.st1;
      `FDCS_A_ST2: rd_mux[7:0] = st_reg.st2;
      `FDCS_A_ST3: rd_mux[7:0] = st_reg.st3;
      `FDCS_A_CFG: rd_mux[0] = st_reg.half_clk;
      `FDCS_A_SPEC: rd_mux[15:0] = {st_reg.step_interval,
        st_reg.unload_delay, st_reg.load_delay, st_reg.dma_bypass};
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.exec_start = 1'b0;
    st_next.param_stb = 1'b0;
    st_next.unl_done = 1'b0;
    st_next.stp_done = 1'b0;
    st_next.ld_done = 1'b0;
    st_next.ms_tick = 1'b0;
    // apb answers one cycle after setup
    st_next.pready = psel && !penable;
    st_next.pslverr = psel && !penable && !mapped;
    if (psel && !penable) begin
      st_next.prdata = rd_mux;
    end
    if (acc && pwrite && paddr == `FDCS_A_CFG) begin
      st_next.half_clk = pwdata[0];
    end
    // command phase
    case (st_reg.phase)
      fdcs_pkg::FDCS_IDLE: begin
        if (cmd_take) begin
          st_next.opcode = pwdata[7:0];
          st_next.st1 = 8'h0;
          st_next.st2 = 8'h0;
          if (bad_cmd) begin
            st_next.res0 = `FDCS_ST0_INVALID; // [R13]
            st_next.res_cnt = 2'h1;
            st_next.phase = fdcs_pkg::FDCS_RESULT; // [R13]
          end else if (op_in == `FDCS_OP_SENSE_INT) begin
            st_next.res0 = st_reg.cause; // [R3]
            st_next.res1 = present_cylinder; // [R24]
            st_next.res_cnt = 2'h2;
            st_next.int_pend = 1'b0; // [R3]
            st_next.seek_pend = 1'b0;
            st_next.cause = `FDCS_ST0_INVALID;
            st_next.phase = fdcs_pkg::FDCS_RESULT;
          end else if (op_in == `FDCS_OP_SPECIFY) begin
            st_next.pleft = 2'h2;
            st_next.phase = fdcs_pkg::FDCS_PARAM;
          end else if (op_in == `FDCS_OP_SENSE_DRV) begin
            st_next.pleft = 2'h1;
            st_next.phase = fdcs_pkg::FDCS_PARAM;
          end else begin
            st_next.exec_start = 1'b1;
            st_next.exec_op = pwdata[7:0];
            st_next.phase = fdcs_pkg::FDCS_EXEC;
          end
        end
      end
      fdcs_pkg::FDCS_PARAM: begin
        if (wr_data) begin
          st_next.pleft = st_reg.pleft - 2'h1;
          if (st_reg.opcode[4:0] == `FDCS_OP_SPECIFY) begin
            if (st_reg.pleft == 2'h2) begin
              st_next.step_interval = pwdata[7:4];
              st_next.unload_delay = pwdata[3:0];
            end else begin
              st_next.load_delay = pwdata[7:1];
              st_next.dma_bypass = pwdata[0]; // [R11]
              st_next.phase = fdcs_pkg::FDCS_IDLE;
            end
          end else begin
            st_next.hd = pwdata[2];
            st_next.us = pwdata[1:0];
            st_next.res0 = {drv_fault, drv_write_protect, drv_ready,
              drv_track_zero, drv_two_sided, pwdata[2:0]}; // [R12]
            st_next.res_cnt = 2'h1;
            st_next.phase = fdcs_pkg::FDCS_RESULT;
          end
        end
      end
      fdcs_pkg::FDCS_EXEC: begin
        if (wr_data) begin
          st_next.param_stb = 1'b1;
          st_next.param_byte = pwdata[7:0];
        end
        if (exec_done) begin
          st_next.phase = fdcs_pkg::FDCS_IDLE;
        end
      end
      fdcs_pkg::FDCS_RESULT: begin
        if (rd_data) begin
          st_next.res_cnt = st_reg.res_cnt - 2'h1;
          st_next.res0 = st_reg.res1;
          if (st_reg.res_cnt == 2'h1) begin
            st_next.phase = fdcs_pkg::FDCS_IDLE;
          end
        end
      end
      default: st_next.phase = fdcs_pkg::FDCS_IDLE;
    endcase
    // interrupt causes; a seek end, or a ready change with no seek pending, wins over the clear above
    st_next.ready_q = drv_ready;
    if (ready_chg && !st_reg.seek_pend) begin
      st_next.cause = `FDCS_ST0_READY_CHG; // [R5]
      st_next.int_pend = 1'b1; // [R1]
    end
    if (seek_end) begin
      st_next.cause = seek_abnormal ? `FDCS_ST0_SEEK_BAD :
        `FDCS_ST0_SEEK_OK; // [R5]
      st_next.int_pend = 1'b1; // [R1]
      st_next.seek_pend = 1'b1; // [R14]
    end
    if (exec_done && st_reg.phase == fdcs_pkg::FDCS_EXEC) begin
      st_next.int_pend = 1'b1; // [R1]
    end
    st_next.int_out = st_next.int_pend ||
      (st_next.phase == fdcs_pkg::FDCS_EXEC && st_next.dma_bypass &&
      exec_byte_req); // [R2]
    // status register one and two
    if (exec_writing && drv_write_protect) begin
      st_next.st1[`FDCS_ST1_WRITE_BLOCKED] = 1'b1; // [R15]
    end
    if (ev_id_missing || ev_data_mark_missing) begin
      st_next.st1[`FDCS_ST1_ID_ABSENT] = 1'b1; // [R16]
    end
    if (ev_data_mark_missing) begin
      st_next.st2[`FDCS_ST2_DATA_ABSENT] = 1'b1; // [R22]
    end
    if (ev_deleted_mark && (exec_reading || exec_scanning)) begin
      st_next.st2[`FDCS_ST2_DELETED] = 1'b1; // [R18]
    end
    if (ev_data_crc) begin
      st_next.st2[`FDCS_ST2_DATA_CRC] = 1'b1; // [R19]
    end
    if (cyl_check && medium_cyl != id_cylinder_store) begin
      st_next.st2[`FDCS_ST2_WRONG_CYL] = 1'b1; // [R20]
      if (medium_cyl == `FDCS_BAD_CYL) begin
        st_next.st2[`FDCS_ST2_BAD_TRACK] = 1'b1; // [R20]
      end
    end
    if (exec_scanning && ev_scan_equal) begin
      st_next.st2[`FDCS_ST2_SCAN_HIT] = 1'b1; // [R21]
    end
    if (exec_scanning && ev_scan_none) begin
      st_next.st2[`FDCS_ST2_SCAN_NOMATCH] = 1'b1; // [R21]
    end
    st_next.st2[7] = 1'b0; // [R17]
    st_next.st3 = {drv_fault, drv_write_protect, drv_ready, drv_track_zero,
      drv_two_sided, st_next.hd, st_next.us}; // [R23]
    // millisecond base, halved clock stretches every interval
    if (st_reg.pre == 14'(MS_CYCLES - 1)) begin
      st_next.pre = 14'h0;
      st_next.ms_odd = !st_reg.ms_odd;
      st_next.ms_tick = !st_reg.half_clk || st_reg.ms_odd; // [R9]
    end else begin
      st_next.pre = st_reg.pre + 14'h1;
    end
    // specify timers
    if (rw_exec_end) begin
      st_next.unl_cnt = 8'({st_reg.unload_delay, 4'h0}); // [R6]
      st_next.unl_run = 1'b1;
    end else if (st_reg.unl_run && st_reg.ms_tick) begin
      st_next.unl_cnt = st_reg.unl_cnt - 8'h1;
      if (st_reg.unl_cnt <= 8'h1) begin
        st_next.unl_run = 1'b0;
        st_next.unl_done = 1'b1;
      end
    end
    if (step_gap_start) begin
      st_next.stp_cnt = 5'(`FDCS_STEP_MAX_MS) -
        {1'b0, st_reg.step_interval}; // [R7]
      st_next.stp_run = 1'b1;
    end else if (st_reg.stp_run && st_reg.ms_tick) begin
      st_next.stp_cnt = st_reg.stp_cnt - 5'h1;
      if (st_reg.stp_cnt <= 5'h1) begin
        st_next.stp_run = 1'b0;
        st_next.stp_done = 1'b1;
      end
    end
    if (head_load_rise) begin
      st_next.ld_cnt = {st_reg.load_delay, 1'b0}; // [R8]
      st_next.ld_run = 1'b1;
    end else if (st_reg.ld_run && st_reg.ms_tick) begin
      st_next.ld_cnt = st_reg.ld_cnt - 8'h1;
      if (st_reg.ld_cnt <= 8'h1) begin
        st_next.ld_run = 1'b0;
        st_next.ld_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.phase <= fdcs_pkg::FDCS_IDLE;
      st_reg.cause <= `FDCS_ST0_INVALID;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign side_select_state = st_reg.hd;
  assign unit_sel_state = st_reg.us;
  assign exec_start = st_reg.exec_start;
  assign exec_opcode = st_reg.exec_op;
  assign param_strobe = st_reg.param_stb;
  assign param_byte = st_reg.param_byte;
  assign int_out = st_reg.int_out;
  assign head_unload = st_reg.unl_done;
  assign step_gap_done = st_reg.stp_done;
  assign rw_start_ok = st_reg.ld_done;
  assign dma_bypass = st_reg.dma_bypass;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_sense_int_clr: assert property ( // [R3]
    cmd_take && op_in == `FDCS_OP_SENSE_INT && !bad_cmd && !ev_any &&
    !exec_byte_req |=> !int_out && st_reg.res1 == $past(present_cylinder))
    else $error("sense interrupt did not clear interrupt");
  a_seek_cause: assert property ( // [R5]
    seek_end && !seek_abnormal |=> st_reg.cause == 8'h20 && int_out)
    else $error("seek end cause wrong");
  a_seek_bad: assert property ( // [R5]
    seek_end && seek_abnormal |=> st_reg.cause == 8'h60)
    else $error("abnormal seek cause wrong");
  a_invalid_cmd: assert property ( // [R13]
    cmd_take && bad_cmd && !ev_any && !st_reg.int_pend |=>
    st_reg.res0 == 8'h80 && st_reg.phase == fdcs_pkg::FDCS_RESULT &&
    !int_out) else $error("invalid command handling wrong");
  a_seek_unsensed: assert property ( // [R14]
    st_reg.seek_pend && cmd_take && op_in == `FDCS_OP_SPECIFY |=>
    st_reg.phase == fdcs_pkg::FDCS_RESULT)
    else $error("unsensed seek did not make command invalid");
  a_nondma_int: assert property ( // [R2]
    st_reg.phase == fdcs_pkg::FDCS_EXEC && st_reg.dma_bypass &&
    exec_byte_req && !exec_done |=> int_out)
    else $error("non-DMA byte request gave no interrupt");
  a_step_load: assert property ( // [R7]
    step_gap_start |=> st_reg.stp_cnt == 5'd16 - $past(st_reg.step_interval))
    else $error("step interval count wrong");
  a_unload_load: assert property ( // [R6]
    rw_exec_end |=> st_reg.unl_cnt == 8'd16 * $past(st_reg.unload_delay))
    else $error("unload delay count wrong");
  a_load_load: assert property ( // [R8]
    head_load_rise |=> st_reg.ld_cnt == 8'd2 * $past(st_reg.load_delay))
    else $error("load delay count wrong");
  a_bad_track: assert property ( // [R20]
    cyl_check && medium_cyl == 8'hff && id_cylinder_store != 8'hff |=>
    st_reg.st2[4] && st_reg.st2[1]) else $error("bad track flags missing");
  a_st2_top: assert property (!st_reg.st2[7]) // [R17]
    else $error("status two bit 7 set");
  a_ms_half: assert property ( // [R9]
    st_reg.ms_tick && $past(st_reg.half_clk) |-> st_reg.ms_odd == 1'b0)
    else $error("half clock tick rate wrong");

  c_sense_int: cover property (cmd_take && op_in == `FDCS_OP_SENSE_INT);
  c_specify: cover property (st_reg.phase == fdcs_pkg::FDCS_PARAM ##1
    st_reg.phase == fdcs_pkg::FDCS_IDLE);
  c_step_done: cover property (step_gap_done);
  c_invalid: cover property (cmd_take && bad_cmd);

endmodule // fdcs_core
`default_nettype wire

// *** verification/fdcs_host_model.sv ***
// host processor model: apb master that issues commands and reads results
`timescale 1ns/1ps
`default_nettype none
module fdcs_host_model (
  // clock
  input wire logic clk_sys,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // ==========================================
  // one transfer, held until pready at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines no longer show the last request
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // fdcs_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench of the floppy command and status block
`timescale 1ns/1ps
`default_nettype none
`include "fdcs_params.svh"
module tb_top;
  localparam int M = 10;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic drv_fault, drv_write_protect, drv_ready, drv_track_zero;
  logic drv_two_sided, side_select_state, exec_start, param_strobe;
  logic [1:0] unit_sel_state;
  logic exec_done, exec_byte_req, exec_writing, exec_reading;
  logic exec_scanning, seek_end, seek_abnormal, ev_id_missing;
  logic ev_data_mark_missing, ev_deleted_mark, ev_data_crc, cyl_check;
  logic ev_scan_equal, ev_scan_none, int_out, rw_exec_end;
  logic step_gap_start, head_load_rise, head_unload, step_gap_done;
  logic rw_start_ok, dma_bypass;
  logic [7:0] present_cylinder, medium_cyl, id_cylinder_store;
  logic [7:0] exec_opcode, param_byte;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  fdcs_host_model host (.clk_sys, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  fdcs_core #(.MS_CYCLES(M)) uut (.clk_sys, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drv_fault,
    .drv_write_protect, .drv_ready, .drv_track_zero, .drv_two_sided,
    .side_select_state, .unit_sel_state, .exec_done, .exec_byte_req,
    .exec_writing, .exec_reading, .exec_scanning, .seek_end,
    .seek_abnormal, .present_cylinder, .ev_id_missing,
    .ev_data_mark_missing, .ev_deleted_mark, .ev_data_crc, .cyl_check,
    .medium_cyl, .id_cylinder_store, .ev_scan_equal, .ev_scan_none,
    .exec_start, .exec_opcode, .param_strobe, .param_byte, .int_out,
    .rw_exec_end, .step_gap_start, .head_load_rise, .head_unload,
    .step_gap_done, .rw_start_ok, .dma_bypass);

  // ==========================================
  // clock, timeout and shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // start timer s, count cycles to its expiry, expect t ms ticks
  task automatic tmr(input int s, input int t);
    int n;
    n = 0;
    @(posedge clk_sys);
    case (s)
      0: rw_exec_end <= 1'b1;
      1: step_gap_start <= 1'b1;
      default: head_load_rise <= 1'b1;
    endcase
    @(posedge clk_sys);
    {rw_exec_end, step_gap_start, head_load_rise} <= 3'b000;
    do begin
      @(negedge clk_sys);
      n++;
    end while ({head_unload, step_gap_done, rw_start_ok} !== 3'b100 >> s
               && n < 3000);
    chk("timer_len", n >= (t - 2) * M && n <= (t + 1) * M + 3, 1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    rd(`FDCS_A_SPEC);
    chk("spec_reset", q, 32'h0);
    rd(8'h1c);
    chk("unmapped_err", e, 1);
    chk("unmapped_rd", q, 32'h0);
  endtask
  task automatic t_ready();
    present_cylinder <= 8'h23;
    drv_ready <= 1'b1;
    tick(3);
    chk("int_ready", int_out, 1);
    wr(`FDCS_A_DATA, `FDCS_OP_SENSE_INT);
    tick(2);
    chk("int_clear", int_out, 0);
    rd(`FDCS_A_DATA);
    chk("st0_ready", q, 32'hc0);
    rd(`FDCS_A_DATA);
    chk("cyl_ready", q, 32'h23);
  endtask
  task automatic t_seek();
    for (int ab = 0; ab < 2; ab++) begin
      seek_abnormal <= ab[0];
      seek_end <= 1'b1;
      tick(1);
      seek_end <= 1'b0;
      tick(2);
      chk("int_seek", int_out, 1);
      wr(`FDCS_A_DATA, `FDCS_OP_SENSE_DRV);
      rd(`FDCS_A_DATA);
      chk("st0_unsensed", q, 32'h80);
      wr(`FDCS_A_DATA, `FDCS_OP_SENSE_INT);
      rd(`FDCS_A_DATA);
      chk("st0_seek", q, ab ? 32'h60 : 32'h20);
      rd(`FDCS_A_DATA);
      chk("cyl_seek", q, 32'h23);
    end
  endtask
  task automatic t_drive();
    drv_fault <= 1'b1;
    drv_track_zero <= 1'b1;
    wr(`FDCS_A_DATA, `FDCS_OP_SENSE_DRV);
    wr(`FDCS_A_DATA, 32'h05);
    rd(`FDCS_A_DATA);
    chk("status_three", q, 32'hb5);
    chk("side_out", side_select_state, 1);
    chk("unit_out", unit_sel_state, 2'b01);
  endtask
  task automatic t_invalid();
    for (int i = 0; i < 2; i++) begin
      wr(`FDCS_A_DATA, i ? 32'h1f : 32'h00);
      tick(3);
      chk("int_invalid", int_out, 0);
      rd(`FDCS_A_MAIN);
      chk("main_result", q[7:6], 2'b11);
      rd(`FDCS_A_DATA);
      chk("st0_invalid", q, 32'h80);
    end
  endtask
  task automatic t_spec();
    for (int n = 0; n < 2; n++) begin
      wr(`FDCS_A_DATA, `FDCS_OP_SPECIFY);
      wr(`FDCS_A_DATA, 32'he2); // step one ms above drive need
      wr(`FDCS_A_DATA, 32'h0a | n);
      tick(1);
      chk("dma_bypass", dma_bypass, n[0]);
    end
    rd(`FDCS_A_SPEC);
    chk("spec_codes", q, 32'he20b);
    for (int h = 1; h < 3; h++) begin
      wr(`FDCS_A_CFG, h - 1);
      tmr(0, 32 * h);
      tmr(1, 2 * h);
      tmr(2, 10 * h);
    end
  endtask
  task automatic t_exec();
    logic seen;
    seen = 1'b0;
    wr(`FDCS_A_DATA, 32'h05);
    repeat (3) begin
      @(negedge clk_sys);
      seen |= exec_start;
    end
    chk("exec_start", seen, 1);
    chk("exec_opcode", exec_opcode, 8'h05);
    wr(`FDCS_A_DATA, 32'h5a);
    @(negedge clk_sys);
    chk("param_strobe", param_strobe, 1);
    chk("param_byte", param_byte, 8'h5a);
    chk("int_quiet", int_out, 0);
    @(posedge clk_sys);
    {exec_writing, exec_reading, exec_scanning} <= 3'b111;
    {drv_write_protect, medium_cyl, id_cylinder_store} <= 17'h1ff05;
    {ev_data_mark_missing, ev_deleted_mark, ev_data_crc} <= 3'b111;
    {cyl_check, ev_scan_equal, ev_scan_none} <= 3'b111;
    tick(1);
    {ev_data_mark_missing, ev_deleted_mark, ev_data_crc} <= 3'b000;
    {cyl_check, ev_scan_equal, ev_scan_none} <= 3'b000;
    tick(2);
    rd(`FDCS_A_ST1);
    chk("status_one", q, 32'h03);
    rd(`FDCS_A_ST2);
    chk("status_two", q, 32'h7f);
    exec_byte_req <= 1'b1;
    tick(3);
    chk("int_byte", int_out, 1);
    exec_byte_req <= 1'b0;
    exec_done <= 1'b1;
    tick(1);
    exec_done <= 1'b0;
    tick(2);
    chk("int_result", int_out, 1);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {drv_fault, drv_write_protect, drv_ready, drv_track_zero} = '0;
    {drv_two_sided, exec_done, exec_byte_req, exec_writing} = '0;
    {exec_reading, exec_scanning, seek_end, seek_abnormal} = '0;
    {ev_id_missing, ev_data_mark_missing, ev_deleted_mark} = '0;
    {ev_data_crc, cyl_check, ev_scan_equal, ev_scan_none} = '0;
    {rw_exec_end, step_gap_start, head_load_rise} = '0;
    {present_cylinder, medium_cyl, id_cylinder_store} = '0;
    resetn = 1'b0;
    tick(12);
    resetn <= 1'b1;
    tick(4);
    t_regs();
    t_ready();
    t_seek();
    t_drive();
    t_invalid();
    t_spec();
    t_exec();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
